/* File: verilog/issue_consts.svh */
// constants of the execute-packet issue and condition checker
// assumes inclusion by the top module only
`ifndef ISSUE_CONSTS_SVH
`define ISSUE_CONSTS_SVH

`define FP_WORDS               8
`define PBIT                   0
`define CREG_MSB               31
`define CREG_LSB               29
`define ZBIT                   28
`define CREG_NONE              3'h0
`define CREG_B_FILE_REGISTER_0 3'h1
`define CREG_B_FILE_REGISTER_1 3'h2
`define CREG_B_FILE_REGISTER_2 3'h3
`define CREG_A_FILE_REGISTER_1 3'h4
`define CREG_A_FILE_REGISTER_2 3'h5
`define CREG_RSV_HI            2'h3
`define MAX_READS              4
`define KIND_D                 2'h3
`define LAT_SINGLE             1'h0
`define LAT_MPY                1'h1
`define SIDE_A                 1'h0

`endif

/* File: verilog/issue_pkg.sv */
// types shared by the issue and condition checker
// assumes issue_consts.svh is on the include path
`default_nettype none
package issue_pkg;
  // unit kind: 0 logic, 1 shift, 2 multiply, 3 data-address
  typedef struct packed {
    logic       side;
    logic [1:0] kind;
  } unit_t;

  typedef struct packed {
    logic       side;
    logic [4:0] idx;
  } reg_id_t;

  // per-slot resource description from the predecoder
  typedef struct packed {
    unit_t      unit;
    logic       xpath;
    logic [4:0] src1_idx;
    logic       src1_vld;
    logic [4:0] src2_idx;
    logic       src2_vld;
    reg_id_t    dst;
    logic       dst_vld;
    logic       is_load;
    logic       is_store;
    logic       ptr_side;
    logic       data_side;
    logic       long_wr;
    logic       long_rd;
    logic       is_mpy;
  } slot_desc_t;

  typedef struct packed {
    logic [31:0] b_file_register_0;
    logic [31:0] b_file_register_1;
    logic [31:0] b_file_register_2;
    logic [31:0] a_file_register_1;
    logic [31:0] a_file_register_2;
  } pred_regs_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ISSUE = 2'h1
  } state_t;
endpackage : issue_pkg
`default_nettype wire

/* File: verilog/vliw_issue_condition_checker.sv */
// issue stage: splits fetch packets into execute packets, checks resources
// assumes fetch presents eight words plus predecoded slot descriptions
`include "issue_consts.svh"
`default_nettype none
module vliw_issue_condition_checker
  import issue_pkg::*;
#(
  parameter int MAX_READS = `MAX_READS
) (
  input  wire logic                   clock_in,
  input  wire logic                   rst_b_in,
  input  wire logic                   fp_valid_in,
  output logic                        fp_ready_out,
  input  wire logic [7:0][31:0]       fp_words_in,
  input  wire slot_desc_t [7:0]       fp_desc_in,
  input  wire logic                   branch_valid_in,
  input  wire logic [2:0]             branch_slot_in,
  input  wire pred_regs_t             pred_regs_in,
  output logic                        issue_valid_out,
  output logic [7:0]                  issue_mask_out,
  output logic [7:0][31:0]            issue_words_out,
  output logic [7:0]                  exec_enable_out,
  output logic [7:0]                  src2_side_out,
  output logic                        illegal_out,
  output logic                        write_conflict_out,
  output logic                        breakpoint_out,
  output logic                        reserved_cond_out
);
  if (MAX_READS < 1 || MAX_READS > 15) begin : g_bad_reads
    $error("MAX_READS out of range");
  end

  // ==========================================================
  // reset release
  logic rst_meta_b;
  logic rst_b;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_b <= 1'b0;
      rst_b      <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_b      <= rst_meta_b;
    end
  end

  // ==========================================================
  // predicate decode
  function automatic logic [2:0] pred_eval(input logic [31:0] w, input pred_regs_t p);
    logic [2:0]  creg;
    logic        z;
    logic [31:0] r;
    logic        ok;
    creg = w[`CREG_MSB:`CREG_LSB];
    z    = w[`ZBIT];
    r    = '0;
    ok   = 1'b0;
    unique case (creg)
      `CREG_B_FILE_REGISTER_0: r = p.b_file_register_0;
      `CREG_B_FILE_REGISTER_1: r = p.b_file_register_1;
      `CREG_B_FILE_REGISTER_2: r = p.b_file_register_2;
      `CREG_A_FILE_REGISTER_1: r = p.a_file_register_1;
      `CREG_A_FILE_REGISTER_2: r = p.a_file_register_2;
      default:  r = '0;
    endcase
    if (creg == `CREG_NONE) ok = !z;
    else if (creg[2:1] == `CREG_RSV_HI) ok = 1'b0;
    else ok = z ? (r == '0) : (r != '0);
    // {execute, breakpoint, reserved}
    pred_eval = {ok, (creg == `CREG_NONE) && z, creg[2:1] == `CREG_RSV_HI};
  endfunction : pred_eval

  // ==========================================================
  // fetch packet holding and packet walk
  state_t                state;
  state_t                next_state;
  logic [7:0][31:0]      words;
  logic [7:0][31:0]      next_words;
  slot_desc_t [7:0]      desc;
  slot_desc_t [7:0]      next_desc;
  logic [2:0]            start;
  logic [2:0]            next_start;
  logic [7:0]            mask;
  logic [2:0]            last_idx;
  logic                  chain;
  logic                  issuing;
  logic                  fp_take;

  always_comb begin
    mask     = '0;
    last_idx = 3'h0;
    chain    = 1'b1;
    for (int j = 0; j < `FP_WORDS; j++) begin
      if (j >= int'(start) && chain) begin
        mask[j]  = 1'b1;
        last_idx = 3'(j);
        if (!words[j][`PBIT]) chain = 1'b0;
      end
    end
  end

  assign issuing      = (state == ST_ISSUE);
  // the last slot closes the packet whatever its chain bit says
  assign fp_ready_out = (state == ST_IDLE) || (issuing && last_idx == 3'(`FP_WORDS - 1));
  assign fp_take      = fp_valid_in && fp_ready_out;

  always_comb begin
    next_state = state;
    next_words = words;
    next_desc  = desc;
    next_start = start;
    if (issuing) next_start = 3'(last_idx + 3'h1);
    if (fp_ready_out) next_state = ST_IDLE;
    if (fp_take) begin
      next_state = ST_ISSUE;
      next_words = fp_words_in;
      next_desc  = fp_desc_in;
      next_start = branch_valid_in ? branch_slot_in : 3'h0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      words <= '0;
      desc  <= '0;
      start <= 3'h0;
    end else begin
      state <= next_state;
      words <= next_words;
      desc  <= next_desc;
      start <= next_start;
    end
  end

  // ==========================================================
  // resource checks over the packet being issued
  // exclusive predicates are ignored here on purpose
  logic       unit_conf;
  logic       cross_conf;
  logic       ls_conf;
  logic       long_conf;
  logic       read_conf;
  logic       wr_conf;
  logic [7:0] src2_side;
  logic [7:0] lat;
  logic       any_store;
  logic       any_long_rd;
  reg_id_t [15:0] rd;
  logic [15:0]    rd_vld;
  logic [7:0]     prev_mpy_vld;
  logic [7:0]     next_prev_mpy_vld;
  reg_id_t [7:0]  prev_mpy_dst;
  reg_id_t [7:0]  next_prev_mpy_dst;

  always_comb begin
    unit_conf   = 1'b0;
    cross_conf  = 1'b0;
    ls_conf     = 1'b0;
    long_conf   = 1'b0;
    read_conf   = 1'b0;
    wr_conf     = 1'b0;
    any_store   = 1'b0;
    any_long_rd = 1'b0;
    for (int i = 0; i < `FP_WORDS; i++) begin
      src2_side[i]  = desc[i].dst.side ^ desc[i].xpath;
      lat[i]        = (desc[i].is_mpy && !desc[i].long_wr) ? `LAT_MPY : `LAT_SINGLE;
      rd[2*i]       = '{side: desc[i].unit.side, idx: desc[i].src1_idx};
      rd[2*i+1]     = '{side: src2_side[i], idx: desc[i].src2_idx};
      // predicate register is deliberately not a read here
      rd_vld[2*i]   = mask[i] && desc[i].src1_vld;
      rd_vld[2*i+1] = mask[i] && desc[i].src2_vld;
      if (mask[i] && desc[i].is_store) any_store = 1'b1;
      if (mask[i] && desc[i].long_rd && desc[i].unit.kind != `KIND_D) any_long_rd = 1'b1;
      if (mask[i] && (desc[i].is_load || desc[i].is_store) &&
          desc[i].ptr_side != desc[i].unit.side) ls_conf = 1'b1;
    end
    for (int i = 0; i < `FP_WORDS; i++) begin
      for (int j = i + 1; j < `FP_WORDS; j++) begin
        if (mask[i] && mask[j]) begin
          if (desc[i].unit == desc[j].unit) unit_conf = 1'b1;
          if (desc[i].xpath && desc[j].xpath && desc[i].unit.side == desc[j].unit.side &&
              desc[i].src2_idx != desc[j].src2_idx) cross_conf = 1'b1;
          if ((desc[i].is_load || desc[i].is_store) && (desc[j].is_load || desc[j].is_store) &&
              desc[i].data_side == desc[j].data_side) ls_conf = 1'b1;
          if (desc[i].long_wr && desc[j].long_wr &&
              desc[i].dst.side == desc[j].dst.side) long_conf = 1'b1;
          if (desc[i].dst_vld && desc[j].dst_vld && desc[i].dst == desc[j].dst &&
              lat[i] == lat[j]) wr_conf = 1'b1;
        end
      end
    end
    if (any_store && any_long_rd) long_conf = 1'b1;
    for (int k = 0; k < 16; k++) begin
      automatic logic [4:0] cnt = '0;
      for (int m = 0; m < 16; m++) begin
        if (rd_vld[k] && rd_vld[m] && rd[k] == rd[m]) cnt = cnt + 5'h1;
      end
      if (cnt > 5'(MAX_READS)) read_conf = 1'b1;
    end
    for (int i = 0; i < `FP_WORDS; i++) begin
      if (issuing && mask[i] && desc[i].dst_vld && lat[i] == `LAT_SINGLE) begin
        for (int j = 0; j < `FP_WORDS; j++) begin
          if (prev_mpy_vld[j] && prev_mpy_dst[j] == desc[i].dst) wr_conf = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // multiplies in flight for the next packet's write cycle
  always_comb begin
    for (int i = 0; i < `FP_WORDS; i++) begin
      next_prev_mpy_vld[i] = issuing && mask[i] && desc[i].dst_vld && lat[i] == `LAT_MPY;
      next_prev_mpy_dst[i] = desc[i].dst;
    end
  end

  // ==========================================================
  // first execute phase outputs
  logic [7:0] next_exec;
  logic       next_bkpt;
  logic       next_rsvd;
  always_comb begin
    next_exec = '0;
    next_bkpt = 1'b0;
    next_rsvd = 1'b0;
    for (int i = 0; i < `FP_WORDS; i++) begin
      automatic logic [2:0] pe = pred_eval(words[i], pred_regs_in);
      next_exec[i] = issuing && mask[i] && pe[2];
      if (issuing && mask[i] && pe[1]) next_bkpt = 1'b1;
      if (issuing && mask[i] && pe[0]) next_rsvd = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b) begin
    if (!rst_b) begin
      issue_valid_out    <= 1'b0;
      issue_mask_out     <= '0;
      issue_words_out    <= '0;
      exec_enable_out    <= '0;
      src2_side_out      <= '0;
      illegal_out        <= 1'b0;
      write_conflict_out <= 1'b0;
      breakpoint_out     <= 1'b0;
      reserved_cond_out  <= 1'b0;
      prev_mpy_vld       <= '0;
      prev_mpy_dst       <= '0;
    end else begin
      issue_valid_out    <= issuing;
      issue_mask_out     <= issuing ? mask : 8'h00;
      issue_words_out    <= words;
      exec_enable_out    <= next_exec;
      src2_side_out      <= src2_side;
      illegal_out        <= issuing && (unit_conf || cross_conf || ls_conf ||
                                        long_conf || read_conf);
      // contents of a doubly written register are undefined; only flagged
      write_conflict_out <= issuing && wr_conf;
      breakpoint_out     <= next_bkpt;
      reserved_cond_out  <= next_rsvd;
      prev_mpy_vld       <= next_prev_mpy_vld;
      prev_mpy_dst       <= next_prev_mpy_dst;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b);

  unit_flags_a: assert property (issuing && unit_conf |=> illegal_out)
    else $error("unit conflict not flagged");
  read_count_a: assert property (issuing && read_conf |=> illegal_out && issue_valid_out)
    else $error("read overuse not flagged");
  write_flag_a: assert property (issuing && wr_conf |=> write_conflict_out)
    else $error("write conflict not flagged");
  uncond_exec_a: assert property (issue_mask_out[0] && issue_words_out[0][31:28] == 4'h0
    |-> exec_enable_out[0])
    else $error("unconditional slot not executed");
  bkpt_noexec_a: assert property (issue_mask_out[1] && issue_words_out[1][31:28] == 4'h1
    |-> !exec_enable_out[1] && breakpoint_out)
    else $error("breakpoint pattern executed");
  zero_test_a: assert property (issue_mask_out[3] && issue_words_out[3][31:28] == 4'h3
    |-> exec_enable_out[3] == ($past(pred_regs_in.b_file_register_0) == 32'h0))
    else $error("zero test on b_file_register_0 wrong");
  chain_mask_a: assert property (issue_mask_out[0] && issue_words_out[0][0]
    |-> issue_mask_out[1])
    else $error("chained slot not issued together");
  target_skip_a: assert property (fp_take && branch_valid_in && branch_slot_in != 3'h0
    |=> ##1 !issue_mask_out[0])
    else $error("slot below branch target issued");
  idle_ready_a: assert property (state == ST_IDLE |-> fp_ready_out ##1 !issue_valid_out)
    else $error("idle but not ready");

  full_pkt_c:  cover property (issue_mask_out == 8'hFF);
  branch_in_c: cover property (fp_take && branch_valid_in ##2 issue_valid_out);
  illegal_c:   cover property (illegal_out);
  wr_conf_c:   cover property (write_conflict_out);
endmodule : vliw_issue_condition_checker
`default_nettype wire

/* File: tb/fetch_model.sv */
// fetch side model: offers one fetch packet at a time and holds it until taken
// assumes the issue block drives ready combinationally from its own state
`default_nettype none
module fetch_model
  import issue_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        fp_ready_in,
  output logic             fp_valid_out,
  output logic [7:0][31:0] fp_words_out,
  output slot_desc_t [7:0] fp_desc_out,
  output logic             branch_valid_out,
  output logic [2:0]       branch_slot_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic rdy;

  initial begin
    fp_valid_out = 1'b0;
    fp_words_out = '0;
    fp_desc_out = '0;
    branch_valid_out = 1'b0;
    branch_slot_out = 3'h0;
  end

  // ready has settled by the falling edge; this is what the block samples
  always @(negedge clock_in) rdy = fp_ready_in;

  // =====================================================================
  // offer: optional idle gap, then hold everything until the taking edge
  task automatic offer(input logic [7:0][31:0] w, input slot_desc_t [7:0] d,
                       input logic bv, input logic [2:0] bs, input int gap);
    repeat (gap) @(posedge clock_in);
    @(posedge clock_in);
    fp_valid_out <= 1'b1;
    fp_words_out <= w;
    fp_desc_out <= d;
    branch_valid_out <= bv;
    branch_slot_out <= bs;
    do @(posedge clock_in); while (rdy !== 1'b1);
    // released lines show garbage, never the old packet
    fp_valid_out <= 1'b0;
    fp_words_out <= ~w;
    fp_desc_out <= ~d;
    branch_valid_out <= 1'b0;
    branch_slot_out <= ~bs;
  endtask : offer
endmodule : fetch_model
`default_nettype wire

/* File: tb/vliw_issue_condition_checker_bench.sv */
// directed bench for the issue and condition checker
// assumes the package, the design and fetch_model are compiled first
`default_nettype none
module vliw_issue_condition_checker_bench
  import issue_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic fp_valid, fp_ready, br_valid, issue_valid, illegal, wconf, bpt, rsv;
  logic [2:0]       br_slot;
  logic [7:0][31:0] fp_words, words_o, w;
  slot_desc_t [7:0] fp_desc, d;
  logic [7:0]       mask, en, side;
  pred_regs_t       regs = '0;
  logic [7:0]       q_mask[$], q_en[$], q_side[$];
  logic [3:0]       q_flag[$];
  logic [7:0][31:0] q_words[$];
  int               err_count = 0;
  int               checked = 0;
  int               cycles = 0;

  always #5 clock_in = ~clock_in;

  fetch_model fm (.clock_in(clock_in), .fp_ready_in(fp_ready), .fp_valid_out(fp_valid),
    .fp_words_out(fp_words), .fp_desc_out(fp_desc), .branch_valid_out(br_valid),
    .branch_slot_out(br_slot));

  vliw_issue_condition_checker dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .fp_valid_in(fp_valid), .fp_ready_out(fp_ready), .fp_words_in(fp_words),
    .fp_desc_in(fp_desc), .branch_valid_in(br_valid), .branch_slot_in(br_slot),
    .pred_regs_in(regs), .issue_valid_out(issue_valid), .issue_mask_out(mask),
    .issue_words_out(words_o), .exec_enable_out(en), .src2_side_out(side),
    .illegal_out(illegal), .write_conflict_out(wconf), .breakpoint_out(bpt),
    .reserved_cond_out(rsv));

  always @(posedge clock_in) begin
    if (issue_valid === 1'b1) begin
      q_mask.push_back(mask);
      q_en.push_back(en);
      q_side.push_back(side);
      q_flag.push_back({illegal, wconf, bpt, rsv});
      q_words.push_back(words_o);
    end
  end

  // =====================================================================
  // shared helpers
  task automatic test_done();
    $display("mismatches %0d of %0d comparisons", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // all slots chained, each on its own unit, unconditional
  task automatic clr();
    for (int j = 0; j < 8; j++) begin
      w[j] = {4'h0, 8'h5A, 16'(j), 3'h0, 1'b1};
      d[j] = '0;
      d[j].unit.side = j[0];
      d[j].unit.kind = j[2:1];
    end
  endtask : clr

  task automatic send(input int n, input logic bv, input logic [2:0] bs);
    q_mask.delete();
    q_en.delete();
    q_side.delete();
    q_flag.delete();
    q_words.delete();
    fm.offer(w, d, bv, bs, n % 2);
    for (int i = 0; i < 20 && q_mask.size() < n; i++) @(posedge clock_in);
    repeat (3) @(posedge clock_in);
    chk(q_mask.size(), n);
  endtask : send

  task automatic rc(input logic [1:0] e);
    send(1, 1'b0, 3'h0);
    chk(q_flag[0][3:2], e);
  endtask : rc

  function automatic logic exp_en(input logic [3:0] p, input pred_regs_t r);
    logic [31:0] v;
    case (p[3:1])
      3'h1: v = r.b_file_register_0;
      3'h2: v = r.b_file_register_1;
      3'h3: v = r.b_file_register_2;
      3'h4: v = r.a_file_register_1;
      3'h5: v = r.a_file_register_2;
      default: return p == 4'h0; // breakpoint and reserved never run
    endcase
    return p[0] ? (v == 32'h0) : (v != 32'h0);
  endfunction : exp_en

  // =====================================================================
  // scenarios
  task automatic t_packets();
    clr();
    for (int j = 0; j < 8; j++) w[j][0] = 1'b0;
    send(8, 1'b0, 3'h0);
    for (int j = 0; j < 8; j++) begin
      chk(q_mask[j], 8'h01 << j);
      chk(q_en[j], 8'h01 << j);
      chk(q_words[j][j], w[j]);
    end
    clr();
    send(1, 1'b0, 3'h0);
    chk(q_mask[0], 8'hFF);
    w[0][0] = 1'b0;
    w[1][0] = 1'b0;
    w[4][0] = 1'b0;
    w[7][0] = 1'b0;
    for (int b = 0; b < 2; b++) begin
      send(b ? 2 : 4, b[0], 3'h3);
      chk(q_mask[0], b ? 8'h18 : 8'h01);
      chk(q_mask[b ? 1 : 3], 8'hE0);
    end
  endtask : t_packets

  task automatic t_pred();
    for (int r = 0; r < 2; r++) begin
      for (int h = 0; h < 2; h++) begin
        clr();
        @(posedge clock_in);
        regs <= r ? {32'h3, 32'h0, 32'h9, 32'h0, 32'h6} : {32'h0, 32'h5, 32'h0, 32'h7, 32'h0};
        for (int j = 0; j < 8; j++) w[j][31:28] = 4'(h * 8 + j);
        send(1, 1'b0, 3'h0);
        for (int j = 0; j < 8; j++) chk(q_en[0][j], exp_en(w[j][31:28], regs));
        chk(q_flag[0], h ? 4'h1 : 4'h2);
      end
    end
  endtask : t_pred

  task automatic t_res();
    clr();
    d[1].unit = d[0].unit;
    w[0][31:28] = 4'h2;
    w[1][31:28] = 4'h3;
    rc(2'b10);
    clr();
    for (int j = 0; j < 8; j++) d[j].dst.side = j[1];
    for (int j = 0; j < 8; j++) d[j].xpath = j[0];
    rc(2'b00);
    chk(q_side[0], 8'h66);
    clr();
    d[0].xpath = 1'b1;
    d[2].xpath = 1'b1;
    d[0].src2_vld = 1'b1;
    d[2].src2_vld = 1'b1;
    d[2].src2_idx = 5'h04;
    rc(2'b10);
    clr();
    d[6].is_load = 1'b1;
    d[6].ptr_side = 1'b1;
    rc(2'b10);
    d[6].ptr_side = 1'b0;
    d[7].is_load = 1'b1;
    d[7].ptr_side = 1'b1;
    rc(2'b10);
    d[7].data_side = 1'b1;
    rc(2'b00);
    clr();
    d[0].long_wr = 1'b1;
    d[2].long_wr = 1'b1;
    rc(2'b10);
    d[2].long_wr = 1'b0;
    d[3].long_wr = 1'b1;
    d[3].dst.side = 1'b1;
    rc(2'b00);
    d[0].long_rd = 1'b1;
    d[7].is_store = 1'b1;
    d[7].ptr_side = 1'b1;
    d[7].data_side = 1'b1;
    rc(2'b10);
    clr();
    for (int k = 0; k < 7; k += 2) begin
      d[k].src1_idx = 5'h01;
      d[k].src1_vld = 1'b1;
      d[k].src2_idx = 5'h01;
      d[k].src2_vld = 1'b1;
    end
    d[2].src1_vld = 1'b0;
    d[2].src2_vld = 1'b0;
    d[6].src2_idx = 5'h02;
    rc(2'b10);
    d[0].src1_idx = 5'h00;
    w[0][31:28] = 4'h8;
    rc(2'b00);
  endtask : t_res

  task automatic t_write();
    clr();
    d[0].dst_vld = 1'b1;
    d[2].dst_vld = 1'b1;
    rc(2'b01);
    d[2].dst_vld = 1'b0;
    d[4].dst_vld = 1'b1;
    d[4].is_mpy = 1'b1;
    rc(2'b00);
    clr();
    w[0][0] = 1'b0;
    d[0].unit.kind = 2'h2;
    d[0].is_mpy = 1'b1;
    d[0].dst_vld = 1'b1;
    d[1].dst_vld = 1'b1;
    send(2, 1'b0, 3'h0);
    chk(q_flag[0][2], 1'b0);
    chk(q_flag[1][2], 1'b1);
  endtask : t_write

  initial begin
    repeat (4) @(posedge clock_in);
    rst_b_in <= 1'b1;
    // internal reset copy needs two more edges before a packet may be taken
    repeat (2) @(posedge clock_in);
    t_packets();
    t_pred();
    t_res();
    t_write();
    test_done();
  end
endmodule : vliw_issue_condition_checker_bench
`default_nettype wire
